// file: dma_arbiter.sv
// Operation
// RULE_01: Fixed priority over twelve streams, P0 highest
// RULE_02: Translate through TLB, then issue to memory
// RULE_03: Route read data back to requesting stream
// RULE_04: Every read request is 64 bytes
// RULE_05: Every write request is 64 bytes
// RULE_06: Command fetch P0, indirect DMA P1
// RULE_07: Motion reference fetch tiled at P2
// RULE_08: Bitstream row-store write, full line, P3
// RULE_09: Prediction row-store write, full line, P4
// RULE_10: Bitstream row-store read at P5
// RULE_11: Prediction row-store read at P6
// RULE_12: Intra row-store write, full line, P7
// RULE_13: Deblock row-store write, full line, P8
// RULE_14: Intra row-store read at P9
// RULE_15: Deblock row-store read at P10
// RULE_16: Tiled picture writes P11, partials via read-modify-write
// RULE_17: One grant per clock; requests hold until granted
`timescale 1ns/1ps
module dma_arbiter (
  input  wire logic                               clk_i,
  input  wire logic                               sys_rst_i,
  input  wire logic                               ce_i,
  input  dma_pkg::dma_req_t                       req_i [dma_pkg::NUM_STREAMS],
  output logic      [dma_pkg::NUM_STREAMS-1:0]    gnt_o,
  input  dma_pkg::dma_tlb_wr_t                    tlb_wr_i,
  output dma_pkg::dma_mem_req_t                   mem_req_o,
  input  wire logic                               mem_ready_i,
  input  dma_pkg::dma_mem_rsp_t                   mem_rsp_i,
  output dma_pkg::dma_rd_ret_t                    rd_o
);

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_XLATE  = 4'b0010,
    ST_ISSUE  = 4'b0100,
    ST_RMW_RD = 4'b1000
  } dma_state_t;

  function automatic logic [dma_pkg::LINE_W-1:0] merge_line(
    input logic [dma_pkg::LINE_W-1:0]     new_data,
    input logic [dma_pkg::LINE_W-1:0]     old_data,
    input logic [dma_pkg::LINE_BYTES-1:0] mask
  );
    logic [dma_pkg::LINE_W-1:0] res;
    res = old_data;
    for (int b = 0; b < dma_pkg::LINE_BYTES; b++) begin
      if (mask[b]) begin
        res[b*8 +: 8] = new_data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // True when lvl is the most urgent pending level
  function automatic logic top_pending(
    input logic [dma_pkg::NUM_STREAMS-1:0] vld,
    input logic [dma_pkg::SID_W-1:0]       lvl
  );
    logic [dma_pkg::NUM_STREAMS-1:0] above;
    above = '1;
    above = ~(above << lvl);
    return vld[lvl] && ((vld & above) == '0);
  endfunction

  dma_state_t                      state_q, state_d;
  logic [dma_pkg::SID_W-1:0]       sid_q, sid_d;
  logic [dma_pkg::VADDR_W-1:0]     vaddr_q, vaddr_d;
  logic [dma_pkg::LINE_W-1:0]      data_q, data_d;
  logic [dma_pkg::LINE_BYTES-1:0]  mask_q, mask_d;
  logic [dma_pkg::PADDR_W-1:0]     paddr_q, paddr_d;
  logic                            write_q, write_d;
  logic                            rmw_q, rmw_d;
  logic [dma_pkg::SID_W-1:0]       tag_q, tag_d;
  dma_pkg::dma_rd_ret_t            rd_q, rd_d;

  logic [dma_pkg::NUM_STREAMS-1:0] req_vld;
  logic [dma_pkg::NUM_STREAMS-1:0] pick_oh;
  logic [dma_pkg::SID_W-1:0]       pick_idx;
  logic                            pick_any;
  logic [dma_pkg::PPN_W-1:0]       tlb_ppn;
  logic                            grant;

  always_comb begin
    for (int i = 0; i < dma_pkg::NUM_STREAMS; i++) begin
      req_vld[i] = req_i[i].valid;
    end
  end

  // Stream index doubles as priority level; lowest index wins
  dma_prio_pick u_pick ( // [RULE_01] [RULE_06] [RULE_10] [RULE_11] [RULE_14] [RULE_15]
    .req_i    (req_vld),
    .onehot_o (pick_oh),
    .idx_o    (pick_idx),
    .any_o    (pick_any)
  );

  assign grant = (state_q == ST_IDLE) && pick_any && ce_i;
  assign gnt_o = grant ? pick_oh : '0; // [RULE_17]

  dma_tlb_mem u_tlb (
    .clk_i    (clk_i),
    .ce_i     (ce_i),
    .wr_i     (tlb_wr_i),
    .rd_idx_i (req_i[pick_idx].addr[dma_pkg::PAGE_LSB +: dma_pkg::TLB_IDX_W]),
    .rd_ppn_o (tlb_ppn)
  );

  always_comb begin
    state_d = state_q;
    sid_d   = sid_q;
    vaddr_d = vaddr_q;
    data_d  = data_q;
    mask_d  = mask_q;
    paddr_d = paddr_q;
    write_d = write_q;
    rmw_d   = rmw_q;
    tag_d   = tag_q;
    case (state_q)
      ST_IDLE: begin
        if (pick_any) begin
          sid_d   = pick_idx;
          vaddr_d = req_i[pick_idx].addr;
          data_d  = req_i[pick_idx].wdata;
          mask_d  = req_i[pick_idx].wmask;
          state_d = ST_XLATE;
        end
      end
      ST_XLATE: begin
        // Line-aligned physical address, 64 bytes per request
        paddr_d = {tlb_ppn, vaddr_q[dma_pkg::PAGE_LSB-1:dma_pkg::LINE_LSB],
                   dma_pkg::LINE_LSB'(0)}; // [RULE_02] [RULE_04] [RULE_05]
        write_d = dma_pkg::WRITE_MAP[sid_q];
        tag_d   = sid_q;
        rmw_d   = 1'b0;
        if (sid_q == dma_pkg::S_DEST_WR && mask_q != dma_pkg::FULL_MASK) begin
          write_d = 1'b0; // [RULE_16]
          tag_d   = dma_pkg::RMW_TAG;
          rmw_d   = 1'b1;
        end
        state_d = ST_ISSUE;
      end
      ST_ISSUE: begin
        if (mem_ready_i) begin
          state_d = rmw_q ? ST_RMW_RD : ST_IDLE;
        end
      end
      ST_RMW_RD: begin
        if (mem_rsp_i.valid && mem_rsp_i.tag == dma_pkg::RMW_TAG) begin
          data_d  = merge_line(data_q, mem_rsp_i.data, mask_q); // [RULE_16]
          write_d = 1'b1;
          tag_d   = sid_q;
          rmw_d   = 1'b0;
          state_d = ST_ISSUE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      sid_q   <= '0;
      vaddr_q <= '0;
      data_q  <= '0;
      mask_q  <= '0;
      paddr_q <= '0;
      write_q <= 1'b0;
      rmw_q   <= 1'b0;
      tag_q   <= '0;
    end else if (ce_i) begin
      state_q <= state_d;
      sid_q   <= sid_d;
      vaddr_q <= vaddr_d;
      data_q  <= data_d;
      mask_q  <= mask_d;
      paddr_q <= paddr_d;
      write_q <= write_d;
      rmw_q   <= rmw_d;
      tag_q   <= tag_d;
    end
  end

  always_comb begin
    mem_req_o.valid = (state_q == ST_ISSUE);
    mem_req_o.write = write_q;
    mem_req_o.tiled = dma_pkg::TILED_MAP[sid_q]; // [RULE_07] [RULE_16]
    mem_req_o.tag   = tag_q;
    mem_req_o.addr  = paddr_q;
    mem_req_o.data  = data_q; // [RULE_05] [RULE_08] [RULE_09] [RULE_12] [RULE_13]
  end

  // Read return routing by tag; merge reads never reach a stream
  always_comb begin
    rd_d.valid = '0;
    rd_d.data  = rd_q.data;
    if (mem_rsp_i.valid && mem_rsp_i.tag < dma_pkg::SID_W'(dma_pkg::NUM_STREAMS)) begin
      rd_d.valid[mem_rsp_i.tag] = 1'b1; // [RULE_03]
      rd_d.data  = mem_rsp_i.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_q <= '0;
    end else if (ce_i) begin
      rd_q <= rd_d;
    end
  end

  assign rd_o = rd_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_gnt_one_hot: assert property ($onehot0(gnt_o)) // [RULE_17]
    else $error("more than one grant in a cycle");

  a_gnt_prio_order: assert property ( // [RULE_01]
    (gnt_o != '0) |-> ((req_vld & (gnt_o - 12'h001)) == '0))
    else $error("grant given over a higher priority request");

  a_p0_always_wins: assert property ( // [RULE_06]
    (state_q == ST_IDLE && ce_i && req_vld[0]) |-> gnt_o[0])
    else $error("command fetch not granted while idle");

  a_issue_after_xlate: assert property ( // [RULE_02]
    $rose(mem_req_o.valid) |-> ($past(state_q) == ST_XLATE || $past(state_q) == ST_RMW_RD))
    else $error("memory request without translation");

  a_grant_to_issue: assert property ( // [RULE_02]
    (gnt_o != '0) |=> (state_q == ST_XLATE) ##1 (!ce_i || mem_req_o.valid) [*1])
    else $error("grant did not reach issue after translation");

  a_line_aligned: assert property ( // [RULE_04]
    mem_req_o.valid |-> (mem_req_o.addr[5:0] == 6'h00))
    else $error("memory request not 64-byte aligned");

  a_write_stream_dir: assert property ( // [RULE_05]
    (mem_req_o.valid && mem_req_o.write) |-> dma_pkg::WRITE_MAP[mem_req_o.tag])
    else $error("write issued for a read stream");

  a_tiled_streams: assert property ( // [RULE_07]
    mem_req_o.valid |-> (mem_req_o.tiled == (sid_q == 4'h2 || sid_q == 4'hb)))
    else $error("tiled flag wrong for stream");

  a_read_route: assert property ( // [RULE_03]
    (ce_i && mem_rsp_i.valid && mem_rsp_i.tag < 4'hc)
      |=> (rd_o.valid == (12'h001 << $past(mem_rsp_i.tag)) && rd_o.data == $past(mem_rsp_i.data)))
    else $error("read data not routed to requester");

  a_rmw_merge_write: assert property ( // [RULE_16]
    (ce_i && state_q == ST_RMW_RD && mem_rsp_i.valid && mem_rsp_i.tag == 4'hf)
      |=> (mem_req_o.valid && mem_req_o.write && mem_req_o.tag == 4'hb))
    else $error("merge did not lead to final write");

  a_p1_indirect_dma: assert property ( // [RULE_06]
    (state_q == ST_IDLE && ce_i && top_pending(req_vld, dma_pkg::S_IND_DMA)) |-> gnt_o[1])
    else $error("indirect DMA not granted at its level");

  a_p2_motion_ref: assert property ( // [RULE_07]
    (state_q == ST_IDLE && ce_i && top_pending(req_vld, dma_pkg::S_MOTION_REF)) |-> gnt_o[2])
    else $error("motion reference fetch not granted at its level");

  a_p3_bitstream_wr: assert property ( // [RULE_08]
    (state_q == ST_IDLE && ce_i && top_pending(req_vld, dma_pkg::S_BITS_RS_WR)) |-> gnt_o[3])
    else $error("bitstream row-store write not granted at its level");

  a_p4_predict_wr: assert property ( // [RULE_09]
    (state_q == ST_IDLE && ce_i && top_pending(req_vld, dma_pkg::S_PRED_RS_WR)) |-> gnt_o[4])
    else $error("prediction row-store write not granted at its level");

  a_p5_bitstream_rd: assert property ( // [RULE_10]
    (state_q == ST_IDLE && ce_i && top_pending(req_vld, dma_pkg::S_BITS_RS_RD)) |-> gnt_o[5])
    else $error("bitstream row-store read not granted at its level");

  a_p6_predict_rd: assert property ( // [RULE_11]
    (state_q == ST_IDLE && ce_i && top_pending(req_vld, dma_pkg::S_PRED_RS_RD)) |-> gnt_o[6])
    else $error("prediction row-store read not granted at its level");

  a_p7_intra_wr: assert property ( // [RULE_12]
    (state_q == ST_IDLE && ce_i && top_pending(req_vld, dma_pkg::S_INTRA_WR)) |-> gnt_o[7])
    else $error("intra row-store write not granted at its level");

  a_p8_deblock_wr: assert property ( // [RULE_13]
    (state_q == ST_IDLE && ce_i && top_pending(req_vld, dma_pkg::S_DBLK_WR)) |-> gnt_o[8])
    else $error("deblock row-store write not granted at its level");

  a_p9_intra_rd: assert property ( // [RULE_14]
    (state_q == ST_IDLE && ce_i && top_pending(req_vld, dma_pkg::S_INTRA_RD)) |-> gnt_o[9])
    else $error("intra row-store read not granted at its level");

  a_p10_deblock_rd: assert property ( // [RULE_15]
    (state_q == ST_IDLE && ce_i && top_pending(req_vld, dma_pkg::S_DBLK_RD)) |-> gnt_o[10])
    else $error("deblock row-store read not granted at its level");

  a_p11_dest_wr: assert property ( // [RULE_16]
    (state_q == ST_IDLE && ce_i && top_pending(req_vld, dma_pkg::S_DEST_WR)) |-> gnt_o[11])
    else $error("picture write not granted at lowest level");

  a_issue_held: assert property ( // [RULE_02]
    (mem_req_o.valid && !mem_ready_i)
      |=> (mem_req_o.valid && $stable(mem_req_o.addr) && $stable(mem_req_o.tag)))
    else $error("memory request changed before it was accepted");

  a_one_in_flight: assert property ( // [RULE_17]
    (gnt_o != '0) |=> (gnt_o == '0) [*2])
    else $error("new grant while a request is in flight");

  a_read_stream_dir: assert property ( // [RULE_04]
    (mem_req_o.valid && !mem_req_o.write && mem_req_o.tag != dma_pkg::RMW_TAG)
      |-> !dma_pkg::WRITE_MAP[mem_req_o.tag])
    else $error("read issued for a write stream");

  c_read_granted:  cover property (gnt_o[5] ##[1:8] rd_o.valid[5]);
  c_full_write:    cover property (mem_req_o.valid && mem_req_o.write && mem_ready_i);
  c_rmw_sequence:  cover property (state_q == ST_RMW_RD ##[1:20] mem_req_o.valid && mem_req_o.write);
  c_low_prio_wait: cover property (req_vld[11] && req_vld[0] && gnt_o[0]);
  c_dest_granted:  cover property (gnt_o[11]);

endmodule

// file: dma_mem_model.sv
`timescale 1ns/1ps
module dma_mem_model (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  dma_pkg::dma_mem_req_t mem_req_i,
  output logic                  mem_ready_o,
  output dma_pkg::dma_mem_rsp_t mem_rsp_o
);
  logic [511:0] mem [logic [39:0]];
  logic [511:0] dq  [$];
  logic [3:0]   tq  [$];
  int           wq  [$];
  int           cyc;
  integer       seed;
  logic [39:0]  a;
  initial begin
    cyc = 0;
    seed = 32'h8b1cd0b2;
    mem_ready_o = 1'b0;
    mem_rsp_o = '0;
  end
  always @(posedge clk_i) begin
    cyc++;
    a = mem_req_i.addr;
    if (mem_req_i.valid && mem_ready_o) begin
      if (mem_req_i.write) begin
        mem[a] = mem_req_i.data;
      end else begin
        // Read data is a snapshot taken at acceptance
        tq.push_back(mem_req_i.tag);
        dq.push_back(mem.exists(a) ? mem[a] : {16{a[37:6]}});
        wq.push_back(cyc + 3);
      end
    end
    // Random stalls make the memory slow at times
    mem_ready_o <= !sys_rst_i && (($random(seed) & 3) != 0);
    if (wq.size() != 0 && wq[0] <= cyc) begin
      mem_rsp_o <= '{1'b1, tq.pop_front(), dq.pop_front()};
      void'(wq.pop_front());
    end else begin
      // Idle return lines invert the last tag and data each cycle, with valid low
      mem_rsp_o <= '{1'b0, ~mem_rsp_o.tag, ~mem_rsp_o.data};
    end
  end
endmodule

// file: dma_pkg.sv
package dma_pkg;

  localparam int unsigned NUM_STREAMS = 12;
  localparam int unsigned SID_W       = 4;
  localparam int unsigned VADDR_W     = 32;
  localparam int unsigned PADDR_W     = 40;
  localparam int unsigned LINE_BYTES  = 64;
  localparam int unsigned LINE_W      = LINE_BYTES * 8;
  localparam int unsigned LINE_LSB    = 6;
  localparam int unsigned PAGE_LSB    = 12;
  localparam int unsigned TLB_IDX_W   = 6;
  localparam int unsigned TLB_DEPTH   = 64;
  localparam int unsigned PPN_W       = PADDR_W - PAGE_LSB;

  // Stream numbers, equal to priority level (0 wins)
  localparam logic [SID_W-1:0] S_CMD_FETCH  = 4'h0;
  localparam logic [SID_W-1:0] S_IND_DMA    = 4'h1;
  localparam logic [SID_W-1:0] S_MOTION_REF = 4'h2;
  localparam logic [SID_W-1:0] S_BITS_RS_WR = 4'h3;
  localparam logic [SID_W-1:0] S_PRED_RS_WR = 4'h4;
  localparam logic [SID_W-1:0] S_BITS_RS_RD = 4'h5;
  localparam logic [SID_W-1:0] S_PRED_RS_RD = 4'h6;
  localparam logic [SID_W-1:0] S_INTRA_WR   = 4'h7;
  localparam logic [SID_W-1:0] S_DBLK_WR    = 4'h8;
  localparam logic [SID_W-1:0] S_INTRA_RD   = 4'h9;
  localparam logic [SID_W-1:0] S_DBLK_RD    = 4'ha;
  localparam logic [SID_W-1:0] S_DEST_WR    = 4'hb;
  localparam logic [SID_W-1:0] RMW_TAG      = 4'hf;

  // Streams 3,4,7,8,11 write; the rest read
  localparam logic [NUM_STREAMS-1:0] WRITE_MAP = 12'h998; // [RULE_08] [RULE_09] [RULE_12] [RULE_13]
  // Streams 2 and 11 use tiled addressing
  localparam logic [NUM_STREAMS-1:0] TILED_MAP = 12'h804; // [RULE_07] [RULE_16]
  localparam logic [LINE_BYTES-1:0]  FULL_MASK = 64'hffff_ffff_ffff_ffff;

  typedef struct packed {
    logic                  valid;
    logic [VADDR_W-1:0]    addr;
    logic [LINE_W-1:0]     wdata;
    logic [LINE_BYTES-1:0] wmask;
  } dma_req_t;

  typedef struct packed {
    logic                 en;
    logic [TLB_IDX_W-1:0] idx;
    logic [PPN_W-1:0]     ppn;
  } dma_tlb_wr_t;

  typedef struct packed {
    logic               valid;
    logic               write;
    logic               tiled;
    logic [SID_W-1:0]   tag;
    logic [PADDR_W-1:0] addr;
    logic [LINE_W-1:0]  data;
  } dma_mem_req_t;

  typedef struct packed {
    logic              valid;
    logic [SID_W-1:0]  tag;
    logic [LINE_W-1:0] data;
  } dma_mem_rsp_t;

  typedef struct packed {
    logic [NUM_STREAMS-1:0] valid;
    logic [LINE_W-1:0]      data;
  } dma_rd_ret_t;

endpackage

// file: dma_prio_pick.sv
`timescale 1ns/1ps
module dma_prio_pick (
  input  wire logic [dma_pkg::NUM_STREAMS-1:0] req_i,
  output logic      [dma_pkg::NUM_STREAMS-1:0] onehot_o,
  output logic      [dma_pkg::SID_W-1:0]       idx_o,
  output logic                                 any_o
);

  // Lowest set bit is the highest priority
  always_comb begin
    onehot_o = '0;
    idx_o    = '0;
    any_o    = 1'b0;
    for (int i = dma_pkg::NUM_STREAMS - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        onehot_o = '0;
        onehot_o[i] = 1'b1;
        idx_o    = dma_pkg::SID_W'(i);
        any_o    = 1'b1;
      end
    end
  end

endmodule

// file: dma_tlb_mem.sv
`timescale 1ns/1ps
module dma_tlb_mem (
  input  wire logic                          clk_i,
  input  wire logic                          ce_i,
  input  dma_pkg::dma_tlb_wr_t               wr_i,
  input  wire logic [dma_pkg::TLB_IDX_W-1:0] rd_idx_i,
  output logic      [dma_pkg::PPN_W-1:0]     rd_ppn_o
);

  logic [dma_pkg::PPN_W-1:0] mem_q [dma_pkg::TLB_DEPTH];
  logic [dma_pkg::PPN_W-1:0] ppn_q;

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (wr_i.en) begin
        mem_q[wr_i.idx] <= wr_i.ppn;
      end
      ppn_q <= mem_q[rd_idx_i];
    end
  end

  assign rd_ppn_o = ppn_q;

endmodule

// file: tb_decoder_memory_arbiter.sv
`timescale 1ns/1ps
module tb_decoder_memory_arbiter;
  localparam int N = dma_pkg::NUM_STREAMS;
  logic                  clk_i;
  logic                  sys_rst_i;
  dma_pkg::dma_req_t     req_i [N];
  logic [N-1:0]          gnt_o;
  dma_pkg::dma_tlb_wr_t  tlb_wr_i;
  dma_pkg::dma_mem_req_t mem_req_o;
  logic                  mem_ready_i;
  dma_pkg::dma_mem_rsp_t mem_rsp_i;
  dma_pkg::dma_rd_ret_t  rd_o;
  int                    error_cnt = 0;
  int                    n_checks = 0;
  integer                seed = 32'h8b1cd0b2;
  logic [N-1:0]          pend = '0;
  logic [N-1:0]          shown = '0;
  logic [31:0]           va [N];
  logic [511:0]          wd [N];
  logic [63:0]           wm [N];
  logic [27:0]           ppn [64];
  logic [511:0]          mir [logic [39:0]];
  logic [3:0]            qt [$];
  logic [3:0]            rt [$];
  logic [39:0]           qa [$];
  logic [511:0]          qd [$];
  logic [511:0]          rq [$];
  logic [63:0]           qm [$];

  dma_arbiter dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .req_i(req_i),
    .gnt_o(gnt_o), .tlb_wr_i(tlb_wr_i), .mem_req_o(mem_req_o), .mem_ready_i(mem_ready_i),
    .mem_rsp_i(mem_rsp_i), .rd_o(rd_o));
  dma_mem_model u_mem (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mem_req_i(mem_req_o),
    .mem_ready_o(mem_ready_i), .mem_rsp_o(mem_rsp_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic cmp(input logic [511:0] got, input logic [511:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  function automatic logic [511:0] old(input logic [39:0] a);
    return mir.exists(a) ? mir[a] : {16{a[37:6]}};
  endfunction

  task automatic step;
    int i;
    logic [3:0] t;
    logic [39:0] pa;
    logic [511:0] e;
    logic [63:0] m;
    logic [511:0] o;
    @(posedge clk_i);
    if (gnt_o !== '0) begin
      cmp(gnt_o, shown & (~shown + 1'b1), "grant not highest pending");
      for (i = 0; i < N; i++) if (gnt_o[i] === 1'b1) break;
      if (i < N) begin
        pa = {ppn[va[i][17:12]], va[i][11:6], 6'h0};
        m = (i == 11) ? wm[i] : '1;
        if (m !== '1) begin
          qt.push_back(4'hf); qa.push_back(pa); qd.push_back('0); qm.push_back('1);
        end
        qt.push_back(4'(i)); qa.push_back(pa); qd.push_back(wd[i]); qm.push_back(m);
        pend[i] = 1'b0;
      end
    end
    if (mem_req_o.valid === 1'b1 && mem_ready_i === 1'b1) begin
      if (qt.size() == 0) begin
        cmp(1'b1, 1'b0, "request without grant");
      end else begin
        t = qt.pop_front(); pa = qa.pop_front(); e = qd.pop_front(); m = qm.pop_front();
        cmp({mem_req_o.tag, mem_req_o.addr}, {t, pa}, "tag or address");
        if (t == 4'hf) cmp(mem_req_o.write, 1'b0, "merge read kind");
        else cmp({mem_req_o.write, mem_req_o.tiled},
                 {dma_pkg::WRITE_MAP[t], dma_pkg::TILED_MAP[t]}, "kind");
        if (t != 4'hf && dma_pkg::WRITE_MAP[t]) begin
          o = old(pa);
          for (i = 0; i < 64; i++) if (!m[i]) e[i*8 +: 8] = o[i*8 +: 8];
          cmp(mem_req_o.data, e, "write line");
          mir[pa] = e;
        end else if (t != 4'hf) begin
          rt.push_back(t);
          rq.push_back(old(pa));
        end
      end
    end
    if (rd_o.valid !== '0) begin
      if (rt.size() == 0) begin
        cmp(1'b1, 1'b0, "unexpected return");
      end else begin
        cmp(rd_o.valid, 12'h001 << rt.pop_front(), "return route");
        cmp(rd_o.data, rq.pop_front(), "return data");
      end
    end
    foreach (req_i[k]) req_i[k] <= '{pend[k], va[k], wd[k], wm[k]};
    shown <= pend;
  endtask

  task automatic post(input int k);
    if (!pend[k]) begin
      va[k] = $random(seed);
      wd[k] = {16{$random(seed)}};
      wm[k] = ($random(seed) & 1) ? '1 : {2{$random(seed)}};
      pend[k] = 1'b1;
    end
  endtask

  task automatic drain;
    int w;
    for (w = 0; w < 3000 && (pend != 0 || qt.size() != 0 || rt.size() != 0); w++) step();
    if (w == 3000) begin
      error_cnt++;
      $display("ERROR %0t drain timeout", $time);
      conclude();
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    sys_rst_i = 1'b1;
    tlb_wr_i = '0;
    foreach (req_i[k]) req_i[k] = '0;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int k = 0; k < 64; k++) begin
      @(posedge clk_i);
      ppn[k] = 28'($random(seed));
      tlb_wr_i <= '{1'b1, 6'(k), ppn[k]};
    end
    @(posedge clk_i);
    tlb_wr_i <= '0;
    for (int k = 0; k < N; k++) post(k);
    drain();
    $display("test 1 done: all streams at once");
    repeat (40) begin
      r = $random(seed);
      repeat (r[14:12]) step();
      for (int k = 0; k < N; k++) if (r[k]) post(k);
    end
    drain();
    $display("test 2 done: random arrivals");
    conclude();
  end
endmodule
